// ---- scpc_clock_control.sv ----
// Purpose: system clock and pll control with keyed apb registers
// Assumes: oscillator, crystal and pll lines are sampled as async levels
// Notes: derived clocks are levels rebuilt from sampled edges of pclk
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module scpc_clock_control
    import scpc_pkg::*;
#(
    parameter int LOCK_TIMEOUT_CYCLES = LOCK_TIME_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lp_osc_in, // low power oscillator level
    input wire logic prec_osc_in, // precision oscillator level
    input wire logic crystal_input_pin, // crystal pin level
    input wire logic pll_out_in, // pll output level
    input wire logic pll_lock_in, // analog lock indication
    input wire logic wake_event, // one-cycle wake pulse, same clock
    input wire logic adc_low_power, // adc low power mode, same clock
    output logic [1:0] pll_ref_sel, // reference mux select
    output logic [9:0] pll_mult_factor, // feedback divide ratio
    output logic pll_ref_out, // 32.768 khz reference to pll
    output logic core_clk_out, // divided core clock
    output logic adc_clk_out, // adc clock
    output logic timer_clk_out, // watchdog and wake-up timer clock
    output logic core_enable, // core powered
    output logic periph_enable, // peripherals powered
    output logic pll_enable, // pll powered
    output logic xtal_enable, // crystal circuit powered
    output logic prec_osc_enable, // precision oscillator input powered
    output logic lp_osc_enable, // low power oscillator powered
    output logic lock_late, // lock missed its deadline after wake
    output logic pll_irq // loss-of-lock interrupt request
);
    // two-stage synchronisers, then a third stage for edge detection
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic lp_s;
    logic prec_s;
    logic xtal_s;
    logic pll_s;
    logic lock_s;
    logic lp_rise;
    logic prec_rise;
    logic pll_rise;
    logic lock_fall;
    // register file
    logic [1:0] clock_source_control;
    logic [7:0] power_divider_control;
    logic lock_lost;
    logic waking; // set on wake until lock returns
    // bus decode
    logic wr_en;
    logic rd_en;
    logic [31:0] next_rdata;
    logic next_err;
    // key sequencer per protected register
    logic [1:0] commit;
    logic [7:0] staged [2];
    // dividers
    logic [6:0] core_cnt;
    logic [6:0] adc_cnt;
    logic [6:0] ref_cnt;
    logic [6:0] tmr_cnt;
    logic [2:0] eff_div;
    logic [6:0] core_half;
    logic [$clog2(LOCK_TIMEOUT_CYCLES + 1)-1:0] lock_cnt;

    // bring async levels into pclk domain; lock flops reset high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 5'h10;
            sync2 <= 5'h10;
            sync3 <= 5'h10;
        end else begin
            sync1 <= {pll_lock_in, pll_out_in, crystal_input_pin, prec_osc_in, lp_osc_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign lp_s = sync2[0];
    assign prec_s = sync2[1];
    assign xtal_s = sync2[2];
    assign pll_s = sync2[3];
    assign lock_s = sync2[4];
    assign lp_rise = sync2[0] & ~sync3[0];
    assign prec_rise = sync2[1] & ~sync3[1];
    assign pll_rise = sync2[3] & ~sync3[3];
    assign lock_fall = ~sync2[4] & sync3[4];

    // write takes effect at the edge where pready is sampled high
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready & ~pwrite;

    // key sequencers, one per protected register
    for (genvar g = 0; g < 2; g++) begin : g_key
        localparam logic [31:0] A_PRE = (g == 0) ? ADDR_PLL_PREWRITE_KEY
                                                 : ADDR_POWER_PREWRITE_KEY;
        localparam logic [31:0] A_REG = (g == 0) ? ADDR_CLOCK_SOURCE_CONTROL
                                                 : ADDR_POWER_DIVIDER_CONTROL;
        localparam logic [31:0] A_POST = (g == 0) ? ADDR_PLL_POSTWRITE_KEY
                                                  : ADDR_POWER_POSTWRITE_KEY;
        localparam logic [31:0] K_PRE = (g == 0) ? KEY_PLL_PRE : KEY_POWER_PRE;
        localparam logic [31:0] K_POST = (g == 0) ? KEY_PLL_POST : KEY_POWER_POST;
        scpc_key_state_t state;
        scpc_key_state_t next_state;
        logic next_commit;

        // any write out of order or with a wrong key drops the sequence
        always_comb begin
            next_state = SCPC_KEY_IDLE;
            next_commit = 1'b0;
            if (!wr_en) begin
                next_state = state;
            end else begin
                unique case (state)
                    SCPC_KEY_IDLE: begin
                        if (paddr == A_PRE && pwdata == K_PRE) begin
                            next_state = SCPC_KEY_ARMED;
                        end
                    end
                    SCPC_KEY_ARMED: begin
                        if (paddr == A_REG) begin
                            next_state = SCPC_KEY_HELD;
                        end else if (paddr == A_PRE && pwdata == K_PRE) begin
                            next_state = SCPC_KEY_ARMED;
                        end
                    end
                    SCPC_KEY_HELD: begin
                        if (paddr == A_POST && pwdata == K_POST) begin
                            next_commit = 1'b1;
                        end else if (paddr == A_PRE && pwdata == K_PRE) begin
                            next_state = SCPC_KEY_ARMED;
                        end
                        // otherwise the held value is discarded
                    end
                    default: begin
                        next_state = SCPC_KEY_IDLE;
                    end
                endcase
            end
        end

        // sequencer state and commit strobe
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state <= SCPC_KEY_IDLE;
                commit[g] <= 1'b0;
            end else begin
                state <= next_state;
                commit[g] <= next_commit;
            end
        end

        // value written between the keys waits here
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                staged[g] <= 8'h00;
            end else if (wr_en && state == SCPC_KEY_ARMED && paddr == A_REG) begin
                staged[g] <= pwdata[7:0];
            end
        end
    end

    // clock source control; reserved code keeps the old source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_source_control <= RST_CLOCK_SOURCE[1:0];
        end else if (commit[0] && staged[0][1:0] != REF_RESERVED) begin
            clock_source_control <= staged[0][1:0];
        end
    end

    // power and divider control; wake forces core, periph and pll on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_divider_control <= RST_POWER_DIVIDER;
        end else if (wake_event) begin
            power_divider_control[POW_CORE_EN] <= 1'b1;
            power_divider_control[POW_PERIPH_EN] <= 1'b1;
            power_divider_control[POW_PLL_EN] <= 1'b1;
        end else if (commit[1]) begin
            power_divider_control <= staged[1];
        end
    end

    // locking window opens on wake and closes when lock is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waking <= 1'b0;
        end else if (wake_event) begin
            waking <= 1'b1;
        end else if (lock_s) begin
            waking <= 1'b0;
        end
    end

    // deadline watch for lock after wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt <= '0;
            lock_late <= 1'b0;
        end else if (wake_event) begin
            lock_cnt <= '0;
            lock_late <= 1'b0;
        end else if (waking && !lock_s) begin
            if (lock_cnt == LOCK_TIMEOUT_CYCLES[$bits(lock_cnt)-1:0]) begin
                lock_late <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 1'b1;
            end
        end
    end

    // sticky lock-loss flag; a new loss beats a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_lost <= RST_PLL_STATUS[STA_LOCK_LOST];
        end else if (lock_fall) begin
            lock_lost <= 1'b1;
        end else if (wr_en && paddr == ADDR_PLL_STATUS && pwdata[STA_LOCK_LOST]) begin
            lock_lost <= 1'b0;
        end
    end

    // interrupt request follows the sticky flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_irq <= 1'b0;
        end else begin
            pll_irq <= lock_lost | lock_fall;
        end
    end

    // read mux and unmapped decode; key registers read as zero
    always_comb begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        unique case (paddr)
            ADDR_PLL_STATUS: begin
                next_rdata[STA_XTAL] = xtal_s;
                next_rdata[STA_LOCKED] = lock_s;
                next_rdata[STA_LOCK_LOST] = lock_lost;
            end
            ADDR_CLOCK_SOURCE_CONTROL: next_rdata[1:0] = clock_source_control;
            ADDR_POWER_DIVIDER_CONTROL: next_rdata[7:0] = power_divider_control;
            ADDR_POWER_PREWRITE_KEY, ADDR_POWER_POSTWRITE_KEY,
            ADDR_PLL_PREWRITE_KEY, ADDR_PLL_POSTWRITE_KEY: next_rdata = 32'h00000000;
            default: next_err = 1'b1;
        endcase
    end

    // apb answer: one wait state, everything registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            prdata <= rd_en ? next_rdata : 32'h00000000;
        end
    end

    // power enables, reference select and fixed pll multiplier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_enable <= RST_POWER_DIVIDER[POW_CORE_EN];
            periph_enable <= RST_POWER_DIVIDER[POW_PERIPH_EN];
            pll_enable <= RST_POWER_DIVIDER[POW_PLL_EN];
            xtal_enable <= RST_POWER_DIVIDER[POW_XTAL_EN];
            prec_osc_enable <= RST_POWER_DIVIDER[POW_PREC_EN];
            lp_osc_enable <= 1'b1;
            pll_ref_sel <= RST_CLOCK_SOURCE[1:0];
            pll_mult_factor <= PLL_MULT;
        end else begin
            core_enable <= power_divider_control[POW_CORE_EN];
            periph_enable <= power_divider_control[POW_PERIPH_EN];
            pll_enable <= power_divider_control[POW_PLL_EN];
            xtal_enable <= power_divider_control[POW_XTAL_EN];
            prec_osc_enable <= power_divider_control[POW_PREC_EN];
            lp_osc_enable <= 1'b1;
            pll_ref_sel <= clock_source_control;
            pll_mult_factor <= PLL_MULT;
        end
    end

    // reference: internal oscillators over four, crystal passed through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt <= 7'h00;
            pll_ref_out <= 1'b0;
        end else if (clock_source_control == REF_CRYSTAL) begin
            ref_cnt <= 7'h00;
            pll_ref_out <= xtal_s;
        end else if (clock_source_control == REF_PRECISION ? prec_rise : lp_rise) begin
            if (ref_cnt == OSC_HALF_DIV - 7'h01) begin
                ref_cnt <= 7'h00;
                pll_ref_out <= ~pll_ref_out;
            end else begin
                ref_cnt <= ref_cnt + 7'h01;
            end
        end
    end

    // timer clock: low power oscillator over four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_cnt <= 7'h00;
            timer_clk_out <= 1'b0;
        end else if (lp_rise) begin
            if (tmr_cnt == OSC_HALF_DIV - 7'h01) begin
                tmr_cnt <= 7'h00;
                timer_clk_out <= ~timer_clk_out;
            end else begin
                tmr_cnt <= tmr_cnt + 7'h01;
            end
        end
    end

    // core divide code: three (divide by eight) while locking, else the software field
    assign eff_div = (waking && !lock_s) ? LOCKING_DIV_CODE
                                         : power_divider_control[POW_CD_LSB +: 3];
    assign core_half = 7'((8'h01 << eff_div) >> 1);

    // core clock: toggles every half period of pll edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_cnt <= 7'h00;
            core_clk_out <= 1'b0;
        end else if (eff_div == 3'h0) begin
            core_cnt <= 7'h00;
            core_clk_out <= pll_s;
        end else if (pll_rise) begin
            if (core_cnt >= core_half - 7'h01) begin
                core_cnt <= 7'h00;
                core_clk_out <= ~core_clk_out;
            end else begin
                core_cnt <= core_cnt + 7'h01;
            end
        end
    end

    // adc clock: pll over forty, or low power oscillator in low power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_cnt <= 7'h00;
            adc_clk_out <= 1'b0;
        end else if (adc_low_power) begin
            adc_cnt <= 7'h00;
            adc_clk_out <= lp_s;
        end else if (pll_rise) begin
            if (adc_cnt == ADC_HALF_DIV - 7'h01) begin
                adc_cnt <= 7'h00;
                adc_clk_out <= ~adc_clk_out;
            end else begin
                adc_cnt <= adc_cnt + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- scpc_pkg.sv ----
// Purpose: shared constants for the system clock and pll control block
// Assumes: apb data 32 bits, full 32-bit byte addresses decoded
// Notes: all offsets are byte addresses, one aligned word per register
package scpc_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_PLL_STATUS = 32'hffff0400;
    localparam logic [31:0] ADDR_POWER_PREWRITE_KEY = 32'hffff0404;
    localparam logic [31:0] ADDR_POWER_DIVIDER_CONTROL = 32'hffff0408;
    localparam logic [31:0] ADDR_POWER_POSTWRITE_KEY = 32'hffff040c;
    localparam logic [31:0] ADDR_PLL_PREWRITE_KEY = 32'hffff0410;
    localparam logic [31:0] ADDR_CLOCK_SOURCE_CONTROL = 32'hffff0414;
    localparam logic [31:0] ADDR_PLL_POSTWRITE_KEY = 32'hffff0418;
    // key values
    localparam logic [31:0] KEY_PLL_PRE = 32'h000000aa;
    localparam logic [31:0] KEY_PLL_POST = 32'h00000055;
    localparam logic [31:0] KEY_POWER_PRE = 32'h00000001;
    localparam logic [31:0] KEY_POWER_POST = 32'h000000f4;
    // reset values
    localparam logic [7:0] RST_CLOCK_SOURCE = 8'h00;
    localparam logic [7:0] RST_POWER_DIVIDER = 8'h79;
    localparam logic [2:0] RST_PLL_STATUS = 3'h2;
    // power_divider_control fields
    localparam int POW_CD_LSB = 0;
    localparam int POW_CORE_EN = 3;
    localparam int POW_PERIPH_EN = 4;
    localparam int POW_PLL_EN = 5;
    localparam int POW_XTAL_EN = 6;
    localparam int POW_PREC_EN = 7;
    // pll_status fields
    localparam int STA_LOCK_LOST = 0;
    localparam int STA_LOCKED = 1;
    localparam int STA_XTAL = 2;
    // pll reference selection codes
    localparam logic [1:0] REF_LOW_POWER = 2'h0;
    localparam logic [1:0] REF_PRECISION = 2'h1;
    localparam logic [1:0] REF_CRYSTAL = 2'h2;
    localparam logic [1:0] REF_RESERVED = 2'h3;
    // dividers and multiplier
    localparam logic [9:0] PLL_MULT = 10'h271;
    localparam logic [6:0] ADC_HALF_DIV = 7'h14;
    localparam logic [2:0] LOCKING_DIV_CODE = 3'h3;
    localparam logic [6:0] OSC_HALF_DIV = 7'h02;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int LOCK_TIME_US = 2000;
    localparam int LOCK_TIME_CYC = LOCK_TIME_US * CLK_MHZ;
    // key sequencer states
    typedef enum logic [2:0] {
        SCPC_KEY_IDLE = 3'b001,
        SCPC_KEY_ARMED = 3'b010,
        SCPC_KEY_HELD = 3'b100
    } scpc_key_state_t;
endpackage

// ---- scpc_clock_control_monitor.sv ----
// Purpose: protocol and register checks on the clock control top ports
// Assumes: single pclk domain, presetn async active low
// Notes: keyed changes are allowed only a few cycles after a post key write
`timescale 1ns/1ps
`default_nettype none
module scpc_clock_control_monitor
    import scpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] pll_ref_sel,
    input wire logic [9:0] pll_mult_factor,
    input wire logic core_enable,
    input wire logic lp_osc_enable,
    input wire logic pll_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done; // transfer completes at this edge
    logic [5:0] pll_hist; // recent clock source post key writes
    logic [5:0] pow_hist; // recent power post key writes
    logic [5:0] clr_hist; // recent writes of one to the lock loss flag
    assign done = psel && penable && pready;
    // short history of the events that may legally change outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_hist <= 6'h00;
            pow_hist <= 6'h00;
            clr_hist <= 6'h00;
        end else begin
            pll_hist <= {pll_hist[4:0], done && pwrite && paddr == ADDR_PLL_POSTWRITE_KEY
                && pwdata == KEY_PLL_POST};
            pow_hist <= {pow_hist[4:0], done && pwrite && paddr == ADDR_POWER_POSTWRITE_KEY
                && pwdata == KEY_POWER_POST};
            clr_hist <= {clr_hist[4:0], done && pwrite && paddr == ADDR_PLL_STATUS && pwdata[0]};
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    a_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error response with data");
    a_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_mult_fixed: assert property (pll_mult_factor == 10'h271)
        else $error("multiplier not fixed");
    a_lp_always: assert property (lp_osc_enable)
        else $error("low power oscillator disabled");
    a_ref_legal: assert property (pll_ref_sel != REF_RESERVED)
        else $error("reserved reference selected");
    a_ref_keyed: assert property ($changed(pll_ref_sel) |-> |pll_hist)
        else $error("reference changed without keys");
    a_core_keyed: assert property ($fell(core_enable) |-> |pow_hist)
        else $error("core disabled without keys");
    a_irq_sticky: assert property ($fell(pll_irq) |-> |clr_hist)
        else $error("lock loss request cleared by itself");
    a_status_rsvd: assert property (done && !pwrite && paddr == ADDR_PLL_STATUS
        |-> prdata[31:3] == 29'h0)
        else $error("status reserved bits set");
endmodule
bind scpc_clock_control scpc_clock_control_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_ref_sel(pll_ref_sel),
    .pll_mult_factor(pll_mult_factor), .core_enable(core_enable),
    .lp_osc_enable(lp_osc_enable), .pll_irq(pll_irq));
`default_nettype wire

// ---- test_system_clock_pll_control.sv ----
// Purpose: register level test of the clock control block over apb
// Assumes: oscillators and pll modelled as pclk based square waves
// Notes: derived clock rates are judged by counting rising edges
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_pll_control
    import scpc_pkg::*;
();
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic pready, pslverr, lp_osc_in = 0, prec_osc_in = 0, crystal_input_pin = 0;
    logic pll_out_in = 0, pll_lock_in = 1, wake_event = 0, adc_low_power = 0;
    logic [1:0] pll_ref_sel;
    logic [9:0] pll_mult_factor;
    logic pll_ref_out, core_clk_out, adc_clk_out, timer_clk_out, core_enable, periph_enable;
    logic pll_enable, xtal_enable, prec_osc_enable, lp_osc_enable, lock_late, pll_irq;
    logic [1:0] xtal_mode = 2'h0; // crystal: 0 low, 1 high, 2 toggling
    int cyc = 0, err_count = 0, comparisons = 0;
    int rises [4] = '{0, 0, 0, 0}; // rising edges: core, adc, timer, reference
    logic [3:0] prev = 4'h0;
    wire [3:0] mon = {pll_ref_out, timer_clk_out, adc_clk_out, core_clk_out};
    scpc_clock_control #(.LOCK_TIMEOUT_CYCLES(50)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lp_osc_in(lp_osc_in),
        .prec_osc_in(prec_osc_in), .crystal_input_pin(crystal_input_pin),
        .pll_out_in(pll_out_in), .pll_lock_in(pll_lock_in), .wake_event(wake_event),
        .adc_low_power(adc_low_power), .pll_ref_sel(pll_ref_sel),
        .pll_mult_factor(pll_mult_factor), .pll_ref_out(pll_ref_out),
        .core_clk_out(core_clk_out), .adc_clk_out(adc_clk_out),
        .timer_clk_out(timer_clk_out), .core_enable(core_enable),
        .periph_enable(periph_enable), .pll_enable(pll_enable), .xtal_enable(xtal_enable),
        .prec_osc_enable(prec_osc_enable), .lp_osc_enable(lp_osc_enable),
        .lock_late(lock_late), .pll_irq(pll_irq));
    // 200 mhz clock
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // oscillators: low power period 16, precision 12, pll 4, crystal 20
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        lp_osc_in <= cyc[3];
        prec_osc_in <= (cyc % 12) < 6;
        pll_out_in <= cyc[1];
        crystal_input_pin <= xtal_mode[1] ? (cyc % 20) < 10 : xtal_mode[0];
        prev <= mon;
        for (int i = 0; i < 4; i++) begin
            if (mon[i] === 1'b1 && prev[i] === 1'b0) begin
                rises[i] <= rises[i] + 1;
            end
        end
    end
    // print counts and verdict, then stop
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // compare one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd,
        output logic er);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // read and compare data and error flag
    task automatic rdc(input logic [31:0] a, exp, input logic eexp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, eexp});
    endtask
    // pre key, register, post key, then let the commit land
    task automatic seq(input logic [31:0] pa, pv, ra, rv, qa, qv);
        wr(pa, pv);
        wr(ra, rv);
        wr(qa, qv);
        repeat (6) @(posedge pclk);
    endtask
    // count rising edges of one derived clock over 640 cycles, allow one either way
    task automatic rate(input int idx, input int period);
        int c0;
        c0 = rises[idx];
        repeat (640) @(posedge pclk);
        check({31'h0, (rises[idx] - c0 - 640 / period + 1) inside {[0:2]}}, 32'h1);
    endtask
    task automatic csc(input logic [31:0] v);
        seq(ADDR_PLL_PREWRITE_KEY, KEY_PLL_PRE, ADDR_CLOCK_SOURCE_CONTROL, v,
            ADDR_PLL_POSTWRITE_KEY, KEY_PLL_POST);
    endtask
    task automatic pdc(input logic [31:0] v);
        seq(ADDR_POWER_PREWRITE_KEY, KEY_POWER_PRE, ADDR_POWER_DIVIDER_CONTROL, v,
            ADDR_POWER_POSTWRITE_KEY, KEY_POWER_POST);
    endtask
    // main sequence
    initial begin
        int per [4] = '{64, 48, 20, 20};
        repeat (16) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        rdc(ADDR_PLL_STATUS, 32'h2, 0);
        rdc(ADDR_CLOCK_SOURCE_CONTROL, 32'h0, 0);
        rdc(ADDR_POWER_DIVIDER_CONTROL, 32'h79, 0);
        check({22'h0, pll_mult_factor}, 32'h271);
        check({31'h0, lp_osc_enable}, 32'h1);
        rate(0, 8);
        rate(1, 160);
        rate(2, 64);
        rdc(ADDR_PLL_PREWRITE_KEY, 32'h0, 0);
        rdc(32'hffff041c, 32'h0, 1);
        xtal_mode <= 2'h1;
        repeat (4) @(posedge pclk);
        rdc(ADDR_PLL_STATUS, 32'h6, 0);
        $display("reset and map test done");
        xtal_mode <= 2'h2;
        for (int c = 0; c < 4; c++) begin
            csc(c);
            rdc(ADDR_CLOCK_SOURCE_CONTROL, (c == 3) ? 32'h2 : c, 0);
            check({30'h0, pll_ref_sel}, (c == 3) ? 32'h2 : c);
            rate(3, per[c]);
        end
        xtal_mode <= 2'h0;
        csc(0);
        seq(ADDR_PLL_PREWRITE_KEY, 32'hab, ADDR_CLOCK_SOURCE_CONTROL, 1,
            ADDR_PLL_POSTWRITE_KEY, KEY_PLL_POST);
        seq(ADDR_PLL_PREWRITE_KEY, KEY_PLL_PRE, ADDR_CLOCK_SOURCE_CONTROL, 1,
            ADDR_PLL_POSTWRITE_KEY, 32'h54);
        seq(ADDR_POWER_PREWRITE_KEY, KEY_POWER_PRE, ADDR_CLOCK_SOURCE_CONTROL, 1,
            ADDR_POWER_POSTWRITE_KEY, KEY_POWER_POST);
        seq(ADDR_PLL_PREWRITE_KEY, KEY_PLL_PRE, ADDR_POWER_DIVIDER_CONTROL, 0,
            ADDR_PLL_POSTWRITE_KEY, KEY_PLL_POST);
        wr(ADDR_CLOCK_SOURCE_CONTROL, 1);
        rdc(ADDR_CLOCK_SOURCE_CONTROL, 32'h0, 0);
        rdc(ADDR_POWER_DIVIDER_CONTROL, 32'h79, 0);
        $display("key test done");
        for (int d = 0; d < 8; d++) begin
            pdc(32'h78 | d);
            rdc(ADDR_POWER_DIVIDER_CONTROL, 32'h78 | d, 0);
            if (d < 4) begin
                rate(0, 4 << d);
            end
        end
        adc_low_power <= 1;
        rate(1, 16);
        adc_low_power <= 0;
        $display("divider test done");
        pdc(32'h0);
        check({31'h0, core_enable}, 32'h0);
        pll_lock_in <= 0;
        repeat (4) @(posedge pclk);
        wake_event <= 1;
        @(posedge pclk);
        wake_event <= 0;
        repeat (8) @(posedge pclk);
        check({29'h0, core_enable, periph_enable, pll_enable}, 32'h7);
        rdc(ADDR_PLL_STATUS, 32'h1, 0);
        check({31'h0, pll_irq}, 32'h1);
        rate(0, 32);
        check({31'h0, lock_late}, 32'h1);
        pll_lock_in <= 1;
        repeat (8) @(posedge pclk);
        rate(0, 4);
        wr(ADDR_PLL_STATUS, 32'h0);
        rdc(ADDR_PLL_STATUS, 32'h3, 0);
        wr(ADDR_PLL_STATUS, 32'h1);
        repeat (4) @(posedge pclk);
        rdc(ADDR_PLL_STATUS, 32'h2, 0);
        check({31'h0, pll_irq}, 32'h0);
        $display("wake test done");
        end_of_test();
    end
endmodule
`default_nettype wire
